// *** adc_frame_pkg.sv ***
// constants shared by the serial conversion frame logic
package adc_frame_pkg;

    // conversion geometry, counted in internal bit clock cycles
    localparam int RESULT_BITS = 10;
    localparam int CTRL_BITS = 8;
    localparam int CONV_CYCLES = 16;

    // slot positions within one conversion (slot 0 starts at the first falling edge)
    localparam logic [3:0] TRACK_CYCLES = 4'h3;
    localparam logic [3:0] HOLD_POS = 4'h3;
    localparam logic [3:0] RESULT_LAST_POS = 4'hc;
    localparam logic [3:0] WORD_DONE_POS = 4'h8;
    localparam logic [3:0] GAP_POS = 4'hf;
    localparam logic [3:0] FIRST_POS = 4'h0;
    localparam logic [3:0] POS_STEP = 4'h1;

    // control word layout
    localparam int CHAN_LO_BIT = 3;
    localparam int CHAN_MID_BIT = 4;
    localparam int CHAN_HI_BIT = 5;
    localparam logic [7:0] CHAN_FIELD_MASK = 8'h38;

    // values after reset
    localparam logic [7:0] RESET_WORD = 8'h00;
    localparam logic [9:0] RESET_RESULT = 10'h000;
    localparam logic RESET_CHAN = 1'b0;

endpackage : adc_frame_pkg

// *** sar_step_if.sv ***
// one successive-approximation trial between the frame logic and the comparator step
`timescale 1ns/1ps
interface sar_step_if;
    logic [9:0] sample;
    logic [9:0] trial_base;
    logic [3:0] bit_index;
    logic decided;
    logic [9:0] next_acc;

    modport step (input sample, input trial_base, input bit_index,
                  output decided, output next_acc);
    modport user (output sample, output trial_base, output bit_index,
                  input decided, input next_acc);
endinterface : sar_step_if

// *** sar_step.sv ***
// one comparator decision of the successive-approximation search
`timescale 1ns/1ps
module sar_step
    import adc_frame_pkg::*;
(
    sar_step_if.step sar
);
    logic [9:0] candidate;

    // trial code adds the bit under test to the bits already kept
    assign candidate = sar.trial_base | (10'h001 << sar.bit_index);
    assign sar.decided = (sar.sample >= candidate);
    assign sar.next_acc = sar.decided ? candidate : sar.trial_base;
endmodule : sar_step

// *** serial_conv_frame.sv ***
// serial frame, track/hold sequencing and result shifting of a two-input converter
`timescale 1ns/1ps
module serial_conv_frame
    import adc_frame_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic [9:0] analog_input_a,
    input wire logic [9:0] analog_input_b,
    output logic sample_switch,
    output logic comparator_balance_switch,
    output logic powered_down,
    output logic [7:0] next_channel_select_word,
    output logic selected_channel,
    output logic chan_addr_fault,
    output logic [9:0] result_word,
    output logic result_channel,
    output logic result_valid
);

    // ---------------------------------------------------------------
    // link domain: internal bit clock, gated by the frame select
    // ---------------------------------------------------------------
    logic open_low;
    logic begun;
    logic [3:0] pos;
    logic dout_bit;
    logic word_flag;
    logic res_flag;
    logic [9:0] held;
    logic [9:0] acc;
    logic conv_chan;
    logic chan_sync1;
    logic chan_sync2;
    logic [9:0] a_sync1;
    logic [9:0] a_sync2;
    logic [9:0] b_sync1;
    logic [9:0] b_sync2;
    logic [7:0] ctrl_shift;

    // system-domain state read back by the link side
    logic chan_is_b;

    // clock level seen at the select fall decides whether that fall already
    // counts as the first internal falling edge; edges too close together
    // make this capture ambiguous, which is why the host keeps its margins
    always_ff @(negedge cs_n) begin
        open_low <= ~sclk;
    end

    wire begun_eff = begun | (open_low & ~cs_n);
    wire active = ~cs_n & begun_eff;
    wire [3:0] next_pos = begun_eff ? pos + POS_STEP : FIRST_POS;
    wire hold_start = active & (next_pos == HOLD_POS);
    wire sar_busy = active & (next_pos >= HOLD_POS) & (next_pos <= RESULT_LAST_POS);
    wire [9:0] analog_input_a_s = a_sync2;
    wire [9:0] analog_input_b_s = b_sync2;
    wire [9:0] sel_sample = chan_sync2 ? analog_input_b_s : analog_input_a_s;

    sar_step_if sar ();

    wire next_dout = sar_busy & sar.decided;
    wire next_word_flag = active & (next_pos >= WORD_DONE_POS);
    wire next_res_flag = active & (next_pos >= RESULT_LAST_POS);
    wire ctrl_capture = active & (pos < WORD_DONE_POS);

    // the first trial of a conversion uses the freshly chosen input directly,
    // so the MSB is ready on the very edge that opens the track switch
    assign sar.sample = hold_start ? sel_sample : held;
    assign sar.trial_base = hold_start ? RESET_RESULT : acc;
    assign sar.bit_index = RESULT_LAST_POS - next_pos;

    sar_step u_sar_step (
        .sar(sar)
    );

    // frame sequencing: the select acts as an asynchronous clear, so nothing
    // advances while it is high even if the bit clock keeps running
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            begun <= 1'b0;
            pos <= FIRST_POS;
            dout_bit <= 1'b0;
            word_flag <= 1'b0;
            res_flag <= 1'b0;
        end else begin
            begun <= 1'b1;
            pos <= next_pos;
            dout_bit <= next_dout;
            word_flag <= next_word_flag;
            res_flag <= next_res_flag;
        end
    end

    // the track cycles double as settling time: both synchroniser stages
    // see at least two edges before the hold edge reads them
    always_ff @(negedge sclk) begin
        chan_sync1 <= chan_is_b;
        chan_sync2 <= chan_sync1;
        a_sync1 <= analog_input_a;
        a_sync2 <= a_sync1;
        b_sync1 <= analog_input_b;
        b_sync2 <= b_sync1;
    end

    // sample and search registers; they keep the last result while idle
    always_ff @(negedge sclk) begin
        held <= hold_start ? sel_sample : held;
        acc <= sar_busy ? sar.next_acc : acc;
        conv_chan <= hold_start ? chan_sync2 : conv_chan;
    end

    // control input taken on the first eight rising edges of each conversion
    always_ff @(posedge sclk) begin
        ctrl_shift <= ctrl_capture ? {ctrl_shift[6:0], din} : ctrl_shift;
    end

    assign dout = dout_bit;
    assign dout_oe = ~cs_n;
    assign sample_switch = active & (pos < TRACK_CYCLES);
    assign comparator_balance_switch = active & (pos < TRACK_CYCLES);
    assign powered_down = ~active | (pos == GAP_POS);

    // ---------------------------------------------------------------
    // system domain: control word register and result hand-off
    // ---------------------------------------------------------------
    logic word_s1;
    logic word_s2;
    logic word_s3;
    logic res_s1;
    logic res_s2;
    logic res_s3;

    // flags rise once per conversion and the data behind them stays put for
    // at least seven bit clocks, far longer than this crossing takes
    wire word_edge = word_s2 & ~word_s3;
    wire res_edge = res_s2 & ~res_s3;
    wire [7:0] word_field = ctrl_shift & CHAN_FIELD_MASK;

    always_ff @(posedge clock) begin
        word_s1 <= word_flag;
        word_s2 <= word_s1;
        word_s3 <= word_s2;
        res_s1 <= res_flag;
        res_s2 <= res_s1;
        res_s3 <= res_s2;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            next_channel_select_word <= RESET_WORD;
            chan_is_b <= RESET_CHAN;
            chan_addr_fault <= 1'b0;
        end else if (word_edge) begin
            next_channel_select_word <= word_field;
            // the middle address bit is not honoured; only the low bit steers
            chan_is_b <= ctrl_shift[CHAN_LO_BIT];
            chan_addr_fault <= ctrl_shift[CHAN_MID_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            result_word <= RESET_RESULT;
            result_channel <= RESET_CHAN;
            result_valid <= 1'b0;
        end else begin
            result_valid <= res_edge;
            result_word <= res_edge ? acc : result_word;
            result_channel <= res_edge ? conv_chan : result_channel;
        end
    end

    assign selected_channel = chan_is_b;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_track_window: assert property (
        @(negedge sclk) disable iff (cs_n)
        (begun_eff && pos == FIRST_POS) |->
            sample_switch ##1 sample_switch ##1 sample_switch ##1 !sample_switch)
        else $error("track did not last three bit clocks");

    a_hold_span: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == HOLD_POS) |-> !sample_switch[*8] ##1 !sample_switch[*5])
        else $error("hold was cut short");

    a_retrack_after: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == GAP_POS) |=> (pos == FIRST_POS && sample_switch))
        else $error("next conversion did not return to track");

    a_msb_first_out: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == HOLD_POS) |-> (dout_bit == acc[RESULT_BITS - 1]))
        else $error("first result bit is not the MSB");

    a_lsb_last_out: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == RESULT_LAST_POS) |-> (dout_bit == acc[0]) ##1 !dout_bit)
        else $error("last result bit wrong or not followed by zero");

    a_padding_zero: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && (pos < HOLD_POS || pos > RESULT_LAST_POS)) |-> !dout_bit)
        else $error("padding slot not zero");

    a_gap_sleep: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == GAP_POS) |-> powered_down ##1 !powered_down)
        else $error("gap power-down wrong");

    a_ctrl_freeze: assert property (
        @(posedge sclk) disable iff (cs_n)
        (active && pos == WORD_DONE_POS) |=> $stable(ctrl_shift))
        else $error("control input sampled past eighth edge");

    a_chan_take: assert property (
        @(posedge clock) disable iff (rst)
        word_edge |=> (chan_is_b == $past(ctrl_shift[CHAN_LO_BIT])
            && (next_channel_select_word & ~CHAN_FIELD_MASK) == RESET_WORD))
        else $error("channel field not taken");

    a_result_take: assert property (
        @(posedge clock) disable iff (rst)
        res_edge |=> (result_valid && result_word == $past(acc)) ##1 !result_valid)
        else $error("result hand-off wrong");

    a_power_up_chan: assert property (
        @(posedge clock) disable iff (rst)
        $fell(rst) |-> (!chan_is_b && next_channel_select_word == RESET_WORD))
        else $error("default input is not input a");

    // link-side sequencing checks
    a_slot_advance: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos != GAP_POS) |=> (pos == $past(pos) + POS_STEP))
        else $error("slot counter skipped a bit clock");

    a_first_slot: assert property (
        @(negedge sclk) disable iff (cs_n)
        (!begun_eff) |=> (pos == FIRST_POS && sample_switch))
        else $error("first falling edge did not start track");

    a_hold_captures: assert property (
        @(negedge sclk) disable iff (cs_n)
        hold_start |=> (held == $past(sel_sample)))
        else $error("hold did not keep the tracked level");

    a_channel_follows: assert property (
        @(negedge sclk) disable iff (cs_n)
        hold_start |=> (conv_chan == $past(chan_sync2)))
        else $error("conversion used the wrong input");

    a_awake_in_conv: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos != GAP_POS) |-> !powered_down)
        else $error("powered down inside a conversion");

    a_gap_no_track: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == GAP_POS) |-> !sample_switch)
        else $error("tracking during the gap slot");

    a_flags_rearm: assert property (
        @(negedge sclk) disable iff (cs_n)
        (active && pos == GAP_POS) |=> (!res_flag && !word_flag))
        else $error("hand-off flags did not drop for the next conversion");

    // system-side checks; select is only sampled here, never steered
    a_oe_follows_select: assert property (
        @(posedge clock)
        (dout_oe == !cs_n))
        else $error("output enable does not follow select");

    a_idle_power: assert property (
        @(posedge clock) disable iff (rst)
        cs_n |-> powered_down)
        else $error("not powered down while deselected");

    a_idle_gated: assert property (
        @(posedge clock) disable iff (rst)
        cs_n |-> (!sample_switch && !active))
        else $error("sequencing active while deselected");

    a_fault_tracks_mid: assert property (
        @(posedge clock) disable iff (rst)
        word_edge |=> (chan_addr_fault == $past(ctrl_shift[CHAN_MID_BIT])))
        else $error("middle address bit not flagged");

    a_word_is_field: assert property (
        @(posedge clock) disable iff (rst)
        word_edge |=> (next_channel_select_word == $past(word_field)))
        else $error("stored word is not the address field");

    a_word_masked: assert property (
        @(posedge clock) disable iff (rst)
        ((next_channel_select_word & ~CHAN_FIELD_MASK) == RESET_WORD))
        else $error("ignored control bits were stored");

    a_result_hold: assert property (
        @(posedge clock) disable iff (rst)
        !res_edge |=> $stable(result_word))
        else $error("result word changed without a hand-off");

    a_valid_has_edge: assert property (
        @(posedge clock) disable iff (rst)
        result_valid |-> $past(res_edge))
        else $error("result valid without a finished conversion");

    a_reset_result: assert property (
        @(posedge clock) disable iff (rst)
        $fell(rst) |-> (result_word == RESET_RESULT && !result_valid && !chan_addr_fault))
        else $error("result side not at its reset values");

endmodule : serial_conv_frame

// *** host_serial_model.sv ***
// host serial port model: opens and closes frames, clocks control words in and results out
`timescale 1ns/1ps
module host_serial_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_pin
);
    localparam time HALF = 32ns;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b0 | 1'b1;
        din = 1'b0;
    end
    // stray edges while deselected must not disturb the next frame
    task automatic open_frame(input logic idle_level);
        for (int i = 0; i < 4; i++) begin
            sclk = ~sclk;
            #HALF;
        end
        sclk = idle_level;
        #HALF;
        cs_n = 1'b0;
        #HALF;
    endtask : open_frame
    // one conversion of 16 rising edges; ends with the clock high
    task automatic convert(input logic [7:0] word, output logic [15:0] seen);
        for (int k = 0; k < 16; k++) begin
            if (sclk) begin
                sclk = 1'b0;
            end
            din = (k < 8) ? word[7 - k] : ~din;
            #HALF;
            sclk = 1'b1;
            seen = {seen[14:0], dout_pin};
            #HALF;
        end
    endtask : convert
    task automatic close_frame();
        cs_n = 1'b1;
        #HALF;
    endtask : close_frame
endmodule : host_serial_model

// *** test_dual_channel_adc_serial_frame_control.sv ***
// self-checking bench of the serial conversion frame logic
`timescale 1ns/1ps
module test_dual_channel_adc_serial_frame_control;
    import adc_frame_pkg::*;
    logic clock, rst, dout, dout_oe, sample_switch, comparator_balance_switch, powered_down;
    logic selected_channel, chan_addr_fault, result_channel, result_valid, got_chan;
    logic [9:0] analog_input_a, analog_input_b, result_word, got_word;
    logic [7:0] next_channel_select_word;
    logic [15:0] trk, pdn;
    wire sclk, cs_n, din, dout_pin;
    int err_count = 0;
    int checks_done = 0;
    assign dout_pin = dout_oe ? dout : 1'bz;
    host_serial_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_pin(dout_pin));
    serial_conv_frame DUT (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .analog_input_a(analog_input_a),
        .analog_input_b(analog_input_b), .sample_switch(sample_switch),
        .comparator_balance_switch(comparator_balance_switch), .powered_down(powered_down),
        .next_channel_select_word(next_channel_select_word),
        .selected_channel(selected_channel), .chan_addr_fault(chan_addr_fault),
        .result_word(result_word), .result_channel(result_channel),
        .result_valid(result_valid));
    // slot trace per conversion, one bit per rising edge
    always @(posedge sclk) begin
        if (!cs_n) begin
            trk <= {trk[14:0], sample_switch & comparator_balance_switch};
            pdn <= {pdn[14:0], powered_down};
        end
    end
    always @(posedge clock) begin
        if (result_valid === 1'b1) begin
            got_word <= result_word;
            got_chan <= result_channel;
        end
    end
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk_vec
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_vec({15'h0, got}, {15'h0, exp}, msg);
    endtask : chk_bit
    task automatic set_levels(input logic [9:0] a, input logic [9:0] b);
        @(posedge clock);
        analog_input_a <= a;
        analog_input_b <= b;
        repeat (2) @(posedge clock);
    endtask : set_levels
    // one conversion; the result hand-off lands well before the sixteenth rise
    task automatic do_conv(input logic [7:0] word, input logic [9:0] code, input logic chan);
        logic [15:0] seen;
        host.convert(word, seen);
        chk_vec(seen, {3'b000, code, 3'b000}, "result bits");
        chk_vec(trk, 16'he000, "track slots");
        chk_vec(pdn, 16'h0001, "power-down slots");
        chk_vec({6'h00, got_word}, {6'h00, code}, "result word");
        chk_bit(got_chan, chan, "result channel");
    endtask : do_conv
    task automatic t_first_conv();
        set_levels(10'h2a5, 10'h15a);
        host.open_frame(1'b1);
        do_conv(8'h08, 10'h2a5, 1'b0);
        chk_vec({8'h00, next_channel_select_word}, 16'h0008, "stored word");
        chk_bit(selected_channel, 1'b1, "next channel");
        host.close_frame();
        chk_bit(dout_pin, 1'bz, "output released");
        chk_bit(powered_down, 1'b1, "idle power-down");
    endtask : t_first_conv
    // full-scale codes, ignored bits set, then a forbidden middle address bit
    task automatic t_back_to_back();
        set_levels(10'h3ff, 10'h000);
        host.open_frame(1'b0);
        do_conv(8'hc7, 10'h000, 1'b1);
        chk_vec({8'h00, next_channel_select_word}, 16'h0000, "masked word");
        do_conv(8'h28, 10'h3ff, 1'b0);
        chk_bit(selected_channel, 1'b1, "address hi ignored");
        do_conv(8'h18, 10'h000, 1'b1);
        chk_bit(chan_addr_fault, 1'b1, "middle bit flagged");
        host.close_frame();
        chk_bit(dout_pin, 1'bz, "output released");
    endtask : t_back_to_back
    task automatic finish_test();
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // both scenarios together take about 4.5 us of bit clock
    initial begin
        #100us;
        err_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        rst = 1'b1;
        analog_input_a = 10'h000;
        analog_input_b = 10'h000;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_first_conv();
        t_back_to_back();
        finish_test();
    end
endmodule : test_dual_channel_adc_serial_frame_control
